// ===== design/floppy_drive_pin_interface.sv
// Pin multiplexer between the floppy controller, the drive connector, the
// eight parallel data pins and the second density select pin.
// Assumes all inputs are synchronous to clk and pin levels are resolved outside.
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module floppy_drive_pin_interface #(
  parameter int ADDR_W = 4
) (
  input wire logic clk, // System clock, 25 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic [ADDR_W-1:0] reg_addr, // Register address.
  input wire logic [7:0] reg_wdata, // Register write data.
  input wire logic reg_write, // Write strobe.
  input wire logic reg_read, // Read strobe.
  output logic [7:0] reg_rdata, // Read data, one cycle after the strobe.
  input wire floppy_pin_pkg::ctl_drive_t ctl, // Controller drive requests.
  output floppy_pin_pkg::drive_in_t ctl_drive_in, // Merged status to controller.
  input wire floppy_pin_pkg::drive_in_t drive_in, // Primary connector inputs.
  output floppy_pin_pkg::drive_od_t drive_od_o, // Open-drain pin levels.
  output floppy_pin_pkg::drive_od_t drive_od_oe, // Open-drain enables, high pulls low.
  output logic [4:0] input_pullup_en, // Pull-up enables for the status inputs.
  input wire logic [7:0] pp_data_o, // Parallel port core data out.
  input wire logic [7:0] pp_data_oe, // Parallel port core data enable.
  output logic [7:0] pp_data_i, // Parallel data back to the port core.
  input wire logic [7:0] par_data_i, // Parallel data pin levels.
  output logic [7:0] par_data_o, // Parallel data pin drive.
  output logic [7:0] par_data_oe, // Parallel data pin enables.
  input wire logic density_sel_1_i, // Second density pin level.
  output logic density_sel_1_o, // Second density pin drive.
  output logic density_sel_1_oe, // Second density pin enable.
  input wire logic gpio1_bit0_o, // General purpose core drive.
  input wire logic gpio1_bit0_oe, // General purpose core enable.
  output logic gpio1_bit0_i, // Pin level to the general purpose core.
  output logic irq_channel_in_1, // Pin level as interrupt channel input.
  input wire logic kbd_ctrl_port_bit12_o, // Keyboard port drive.
  input wire logic kbd_ctrl_port_bit12_oe, // Keyboard port enable.
  output logic kbd_ctrl_port_bit12_i, // Pin level to the keyboard port.
  input wire logic system_ctrl_irq // System control interrupt source.
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  // The map needs four distinct word addresses.
  if (ADDR_W < 2)
  begin : g_bad_addr
    $error("ADDR_W must be at least 2");
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [1:0] pin_select_cfg_a_reg;
  logic [7:0] floppy_cfg_f_reg;
  logic [1:0] port_mode_reg;
  logic [7:0] reg_rdata_reg;
  logic [7:0] rdata_next;
  logic hit;

  // Upper address bits must be zero, so aliases read as unmapped.
  assign hit = (reg_addr >> 2) == '0;

  // Software writes; reserved mode code 3 behaves as printer mode.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_select_cfg_a_reg <= floppy_pin_pkg::PIN_SELECT_RESET;
      floppy_cfg_f_reg <= floppy_pin_pkg::FLOPPY_CFG_RESET;
      port_mode_reg <= floppy_pin_pkg::PORT_MODE_RESET;
    end
    else if (reg_write && hit)
    begin
      case (reg_addr[1:0])
        floppy_pin_pkg::PIN_SELECT_ADDR[1:0]: pin_select_cfg_a_reg <= reg_wdata[1:0];
        floppy_pin_pkg::FLOPPY_CFG_ADDR[1:0]: floppy_cfg_f_reg <= reg_wdata;
        floppy_pin_pkg::PORT_MODE_ADDR[1:0]: port_mode_reg <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // Read mux; the status word shows the raw primary pins.
  always_comb
  begin
    rdata_next = 8'h00;
    if (hit)
    begin
      case (reg_addr[1:0])
        floppy_pin_pkg::PIN_SELECT_ADDR[1:0]: rdata_next = {6'h00, pin_select_cfg_a_reg};
        floppy_pin_pkg::FLOPPY_CFG_ADDR[1:0]: rdata_next = floppy_cfg_f_reg;
        floppy_pin_pkg::PORT_MODE_ADDR[1:0]: rdata_next = {6'h00, port_mode_reg};
        default: rdata_next = {3'h0, drive_in};
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk)
  begin
    if (reset || !reg_read)
      reg_rdata_reg <= 8'h00;
    else
      reg_rdata_reg <= rdata_next;
  end
  assign reg_rdata = reg_rdata_reg;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  logic ext_mode;
  logic dual_mode;
  logic ext_selected;
  floppy_pin_pkg::drive_in_t ext_in;

  assign dual_mode = port_mode_reg == floppy_pin_pkg::MODE_EXT_DUAL;
  assign ext_mode = dual_mode || port_mode_reg == floppy_pin_pkg::MODE_EXT_SINGLE;
  // Single mode hangs drive B on the extension port; dual mode hangs both.
  assign ext_selected = dual_mode || (ext_mode && ctl.sel_b);
  assign ext_in = {par_data_i[4], par_data_i[3], par_data_i[2], par_data_i[1], par_data_i[0]};

  // ****************************************************************
  // Drive control outputs
  // ****************************************************************
  floppy_pin_pkg::drive_od_t drive_od_oe_reg;
  floppy_pin_pkg::drive_od_t drive_od_oe_next;

  // Open drain: the enable pulls the pin low, so it is the active-low level.
  always_comb
  begin
    drive_od_oe_next.density_sel_0 = !ctl.den0;
    drive_od_oe_next.head = ctl.side1; // [R9]
    drive_od_oe_next.write_en = ctl.write_en;
    drive_od_oe_next.write_serial_out_n = ctl.write_data; // [R12]
    drive_od_oe_next.step = ctl.step; // [R11]
    drive_od_oe_next.dir = ctl.inward; // [R10]
    drive_od_oe_next.motor_b_n = ctl.motor_b; // [R13]
    drive_od_oe_next.motor_a_n = ctl.motor_a; // [R13]
    drive_od_oe_next.drive_sel_a_n = ctl.sel_a; // [R14]
    drive_od_oe_next.drive_sel_b_n = ctl.sel_b; // [R14]
  end

  // The pins are registered, so each follows its request one cycle late.
  always_ff @(posedge clk)
  begin
    if (reset)
      drive_od_oe_reg <= '0;
    else
      drive_od_oe_reg <= drive_od_oe_next;
  end
  assign drive_od_oe = drive_od_oe_reg;
  assign drive_od_o = '0;

  // ****************************************************************
  // Parallel data pins
  // ****************************************************************
  logic [7:0] par_data_o_reg;
  logic [7:0] par_data_oe_reg;
  logic [7:0] pp_data_i_reg;

  // Printer mode passes the port core through; extension modes release all
  // but the two dual-mode outputs, which copy the primary requests.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      par_data_o_reg <= 8'h00;
      par_data_oe_reg <= 8'h00;
    end
    else if (!ext_mode)
    begin
      par_data_o_reg <= pp_data_o; // [R6]
      par_data_oe_reg <= pp_data_oe; // [R6]
    end
    else
    begin
      par_data_o_reg <= 8'h00;
      par_data_oe_reg <= {dual_mode && ctl.sel_a, dual_mode && ctl.motor_a, 6'h00}; // [R3] [R4] [R5] [R21]
    end
  end
  assign par_data_o = par_data_o_reg;
  assign par_data_oe = par_data_oe_reg;

  // The port core sees zero while the pins belong to the drive.
  always_ff @(posedge clk)
  begin
    if (reset || ext_mode)
      pp_data_i_reg <= 8'h00;
    else
      pp_data_i_reg <= par_data_i; // [R6]
  end
  assign pp_data_i = pp_data_i_reg;

  // ****************************************************************
  // Status inputs and pull-ups
  // ****************************************************************
  floppy_pin_pkg::drive_in_t ctl_drive_in_reg;
  logic [4:0] input_pullup_en_reg;

  // Idle high after reset so nothing reads as an active status at once.
  always_ff @(posedge clk)
  begin
    if (reset)
      ctl_drive_in_reg <= '1;
    else if (ext_selected)
      ctl_drive_in_reg <= ext_in; // [R1] [R2] [R20] [R21]
    else
      ctl_drive_in_reg <= drive_in; // [R21]
  end
  assign ctl_drive_in = ctl_drive_in_reg;

  // Pull-ups default on, as the drive outputs are open collector.
  always_ff @(posedge clk)
  begin
    if (reset)
      input_pullup_en_reg <= 5'h1F;
    else
      input_pullup_en_reg <= {5{!floppy_cfg_f_reg[floppy_pin_pkg::PULLUP_DIS_BIT]}}; // [R19]
  end
  assign input_pullup_en = input_pullup_en_reg;

  // ****************************************************************
  // Second density select pin
  // ****************************************************************
  logic den1_o_reg;
  logic den1_oe_reg;
  logic gpio_i_reg;
  logic kbd_i_reg;

  // Pin owner follows the select field.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      den1_o_reg <= 1'b0;
      den1_oe_reg <= 1'b0;
    end
    else
    begin
      case (pin_select_cfg_a_reg)
        floppy_pin_pkg::SEL_DENSITY:
        begin
          den1_o_reg <= 1'b0;
          den1_oe_reg <= !ctl.den1; // [R7]
        end
        floppy_pin_pkg::SEL_GPIO:
        begin
          den1_o_reg <= gpio1_bit0_o; // [R7]
          den1_oe_reg <= gpio1_bit0_oe;
        end
        floppy_pin_pkg::SEL_KBD:
        begin
          den1_o_reg <= kbd_ctrl_port_bit12_o; // [R8]
          den1_oe_reg <= kbd_ctrl_port_bit12_oe;
        end
        default:
        begin
          den1_o_reg <= system_ctrl_irq; // [R8]
          den1_oe_reg <= 1'b1;
        end
      endcase
    end
  end
  assign density_sel_1_o = den1_o_reg;
  assign density_sel_1_oe = den1_oe_reg;

  // Pin level returns only to the function that owns the pin.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      gpio_i_reg <= 1'b0;
      kbd_i_reg <= 1'b0;
    end
    else
    begin
      gpio_i_reg <= pin_select_cfg_a_reg == floppy_pin_pkg::SEL_GPIO && density_sel_1_i;
      kbd_i_reg <= pin_select_cfg_a_reg == floppy_pin_pkg::SEL_KBD && density_sel_1_i;
    end
  end
  assign gpio1_bit0_i = gpio_i_reg;
  assign irq_channel_in_1 = gpio_i_reg;
  assign kbd_ctrl_port_bit12_i = kbd_i_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic reset_q;

  // Masks the first cycle after reset, whose outputs still hold reset values.
  always_ff @(posedge clk)
  begin
    reset_q <= reset;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || reset_q);

  sequence step_asked;
    !ctl.step ##1 ctl.step;
  endsequence

  sequence step_pulled;
    !drive_od_oe.step ##1 drive_od_oe.step;
  endsequence

  head_polarity_a: assert property (drive_od_oe.head == $past(ctl.side1)) // [R9]
    else $error("head pin polarity wrong");
  dir_polarity_a: assert property (ctl.inward |=> drive_od_oe.dir) // [R10]
    else $error("direction pin not low for inward");
  step_pulse_a: assert property (step_asked |-> step_pulled) // [R11]
    else $error("step request gave no low pulse");
  write_data_a: assert property (drive_od_oe.write_serial_out_n == $past(ctl.write_data)) // [R12]
    else $error("write data pin mismatch");
  motor_pins_a: assert property ({drive_od_oe.motor_a_n, drive_od_oe.motor_b_n}
    == $past({ctl.motor_a, ctl.motor_b})) // [R13]
    else $error("motor pin mismatch");
  select_pins_a: assert property ({drive_od_oe.drive_sel_a_n, drive_od_oe.drive_sel_b_n}
    == $past({ctl.sel_a, ctl.sel_b})) // [R14]
    else $error("drive select pin mismatch");
  ext_inputs_a: assert property ($past(ext_selected) |-> ctl_drive_in == $past(par_data_i[4:0])) // [R1] [R2] [R20]
    else $error("extension inputs not routed");
  primary_inputs_a: assert property (!$past(ext_selected) |-> ctl_drive_in == $past(drive_in)) // [R21]
    else $error("primary inputs not routed");
  ext_released_a: assert property ($past(ext_mode) |-> par_data_oe[5:0] == 6'h00
    && ($past(dual_mode) || par_data_oe[7:6] == 2'h0)) // [R3]
    else $error("unused extension pin driven");
  ext_motor_a: assert property ($past(dual_mode) |-> par_data_oe[6] == $past(ctl.motor_a)) // [R4]
    else $error("extension motor pin mismatch");
  ext_select_a: assert property ($past(dual_mode) |-> par_data_oe[7] == $past(ctl.sel_a)) // [R5]
    else $error("extension select pin mismatch");
  printer_pass_a: assert property (!$past(ext_mode) |-> par_data_oe == $past(pp_data_oe)
    && pp_data_i == $past(par_data_i)) // [R6]
    else $error("printer data not passed");
  den_density_a: assert property ($past(pin_select_cfg_a_reg) == floppy_pin_pkg::SEL_DENSITY
    |-> density_sel_1_oe != $past(ctl.den1)) // [R7]
    else $error("density pin not following bit 1");
  den_sci_a: assert property ($past(pin_select_cfg_a_reg) == floppy_pin_pkg::SEL_SCI
    |-> density_sel_1_oe && density_sel_1_o == $past(system_ctrl_irq)) // [R8]
    else $error("system interrupt not on pin");
  pullup_off_a: assert property (floppy_cfg_f_reg[floppy_pin_pkg::PULLUP_DIS_BIT]
    ##1 floppy_cfg_f_reg[floppy_pin_pkg::PULLUP_DIS_BIT] |-> input_pullup_en == 5'h00) // [R19]
    else $error("pull-ups left on");

endmodule

`default_nettype wire

// ===== design/floppy_pin_pkg.sv
// Constants, register map and signal groups for the floppy drive pin interface.
// Assumes one synchronous clock domain and a plain register port.
//
// Overview of operation
// R1: Extension modes: data bit 3 is the extension read data input.
// R2: Extension modes: data bit 4 is the extension media change input, active low.
// R3: Pins without an extension function are released: bits 5-7 single, bit 5 dual.
// R4: Dual extension mode: data bit 6 drives extension motor A, open drain, low.
// R5: Dual extension mode: data bit 7 drives extension drive select A, low.
// R6: Printer mode: data pins carry the parallel port data bus bits.
// R7: Pin select field 00 gives density bit 1, 01 gives general purpose bit.
// R8: Pin select field 10 gives keyboard port bit, 11 the system interrupt.
// R9: Head select pin high picks side 0, low picks side 1.
// R10: Direction pin high steps outward, low steps inward.
// R11: Step pin pulses low on open drain for each track move.
// R12: Write data pin carries precompensated data, active low, open drain.
// R13: Motor pins are active low: motor A enables drive 0, B drive 1.
// R14: Drive select A and B pins are active low open drain enables.
// R15: The drive holds media change low at power on and on removal.
// R16: The drive holds write protect low for a protected diskette.
// R17: The drive holds track zero low over the outermost track.
// R18: The drive holds index low over the index hole.
// R19: Input pull-ups are off while the pull-up disable bit 7 is set.
// R20: Extension modes: data bits 0, 1, 2 are index, track zero, write protect.
// R21: Extension inputs replace primary inputs for the drive on the extension port.

package floppy_pin_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] PIN_SELECT_ADDR = 4'h0;
  localparam logic [3:0] FLOPPY_CFG_ADDR = 4'h1;
  localparam logic [3:0] PORT_MODE_ADDR = 4'h2;
  localparam logic [3:0] PIN_STATUS_ADDR = 4'h3;
  localparam int PULLUP_DIS_BIT = 7;
  localparam logic [1:0] PIN_SELECT_RESET = 2'h0;
  localparam logic [7:0] FLOPPY_CFG_RESET = 8'h00;
  localparam logic [1:0] PORT_MODE_RESET = 2'h0;

  // ****************************************************************
  // Field encodings
  // ****************************************************************
  localparam logic [1:0] SEL_DENSITY = 2'h0;
  localparam logic [1:0] SEL_GPIO = 2'h1;
  localparam logic [1:0] SEL_KBD = 2'h2;
  localparam logic [1:0] SEL_SCI = 2'h3;
  localparam logic [1:0] MODE_PRINTER = 2'h0;
  localparam logic [1:0] MODE_EXT_SINGLE = 2'h1;
  localparam logic [1:0] MODE_EXT_DUAL = 2'h2;

  // Controller side drive requests, all active high.
  typedef struct packed {
    logic den0;
    logic den1;
    logic side1;
    logic write_en;
    logic write_data;
    logic step;
    logic inward;
    logic motor_a;
    logic motor_b;
    logic sel_a;
    logic sel_b;
  } ctl_drive_t;

  // Drive status inputs as seen on the pins, active low except read data.
  typedef struct packed {
    logic media_change_n;
    logic read_serial_in;
    logic write_protect_n;
    logic track_zero_n;
    logic index_hole_n;
  } drive_in_t;

  // One bit per open-drain drive control pin.
  typedef struct packed {
    logic density_sel_0;
    logic head;
    logic write_en;
    logic write_serial_out_n;
    logic step;
    logic dir;
    logic motor_b_n;
    logic motor_a_n;
    logic drive_sel_a_n;
    logic drive_sel_b_n;
  } drive_od_t;

endpackage

// ===== testbench/floppy_drive_model.sv
// Behavioural floppy drive that answers the pin interface bench.
// Assumes step and direction arrive as resolved levels, high when released.
`timescale 1ns/1ps
`default_nettype none

module floppy_drive_model #(
  parameter int PHASE = 0 // Start of the rotation count.
) (
  input wire logic clk, // Bench clock.
  input wire logic reset, // Power-on, active high.
  input wire logic step_n, // Step pin level.
  input wire logic dir, // Direction pin level, high is outward.
  input wire logic protect, // Diskette is write protected.
  input wire logic eject, // Diskette is removed.
  output floppy_pin_pkg::drive_in_t pins // Status pin levels.
);
  // ****************************************************************
  // Head, media and rotation state
  // ****************************************************************
  logic [6:0] track_reg;
  logic [5:0] turn_reg;
  logic change_reg;
  logic step_last_reg;

  // The head moves on each falling step edge and stops at track zero.
  always @(posedge clk)
  begin
    step_last_reg <= step_n;
    if (reset)
      track_reg <= 7'h00;
    else if (step_last_reg && !step_n && dir && track_reg != 7'h00)
      track_reg <= track_reg - 7'h01;
    else if (step_last_reg && !step_n && !dir)
      track_reg <= track_reg + 7'h01;
  end

  // Only a step clears a change, so software must seek to see a new diskette.
  always @(posedge clk)
  begin
    if (reset || eject)
      change_reg <= 1'b1;
    else if (step_last_reg && !step_n)
      change_reg <= 1'b0;
  end

  // The disk turns freely; index is low for four counts in sixty-four.
  always @(posedge clk)
  begin
    if (reset)
      turn_reg <= 6'(PHASE);
    else
      turn_reg <= turn_reg + 6'h01;
  end

  // Status lines other than read data are low while active.
  assign pins.media_change_n = !change_reg;
  assign pins.read_serial_in = turn_reg[0] ^ turn_reg[2];
  assign pins.write_protect_n = !protect;
  assign pins.track_zero_n = (track_reg != 7'h00);
  assign pins.index_hole_n = (turn_reg >= 6'h04);
endmodule

`default_nettype wire

// ===== testbench/test_floppy_drive_pin_interface.sv
// Self-checking bench for the floppy drive pin interface.
// Assumes one drive on the connector and one on the parallel data pins.
`timescale 1ns/1ps
`default_nettype none

module test_floppy_drive_pin_interface;
  // ****************************************************************
  // Stimulus, pin resolution and design
  // ****************************************************************
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  floppy_pin_pkg::ctl_drive_t ctl = '0;
  logic [7:0] pp_data_o = 8'h00;
  logic [7:0] pp_data_oe = 8'hFF;
  logic [7:0] pp_far = 8'h00;
  logic gp_o = 1'b0;
  logic gp_oe = 1'b0;
  logic kb_o = 1'b0;
  logic kb_oe = 1'b0;
  logic sys_irq = 1'b0;
  logic d1_far = 1'b0;
  logic ext_mode = 1'b0;
  logic ext_protect = 1'b0;
  logic ext_eject = 1'b0;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] reg_rdata, pp_data_i, par_data_i, par_data_o, par_data_oe, par_far;
  floppy_pin_pkg::drive_in_t ctl_drive_in, drive_in, ext_pins;
  floppy_pin_pkg::drive_od_t drive_od_o, drive_od_oe;
  logic [4:0] input_pullup_en;
  logic d1_i, d1_o, d1_oe, gp_i, irq_in, kb_i, step_n, dir_pin;

  // Released pins fall back to the far side; the extension drive owns bits 0-4.
  assign par_far = ext_mode ? {pp_far[7:5], ext_pins} : pp_far;
  assign par_data_i = (par_data_oe & par_data_o) | (~par_data_oe & par_far);
  assign d1_i = d1_oe ? d1_o : d1_far;
  assign step_n = !drive_od_oe.step;
  assign dir_pin = !drive_od_oe.dir;

  always #20 clk = ~clk;

  floppy_drive_pin_interface i_floppy_drive_pin_interface (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .ctl(ctl), .ctl_drive_in(ctl_drive_in),
    .drive_in(drive_in), .drive_od_o(drive_od_o), .drive_od_oe(drive_od_oe),
    .input_pullup_en(input_pullup_en), .pp_data_o(pp_data_o), .pp_data_oe(pp_data_oe),
    .pp_data_i(pp_data_i), .par_data_i(par_data_i), .par_data_o(par_data_o),
    .par_data_oe(par_data_oe), .density_sel_1_i(d1_i), .density_sel_1_o(d1_o),
    .density_sel_1_oe(d1_oe), .gpio1_bit0_o(gp_o), .gpio1_bit0_oe(gp_oe),
    .gpio1_bit0_i(gp_i), .irq_channel_in_1(irq_in), .kbd_ctrl_port_bit12_o(kb_o),
    .kbd_ctrl_port_bit12_oe(kb_oe), .kbd_ctrl_port_bit12_i(kb_i),
    .system_ctrl_irq(sys_irq));

  floppy_drive_model #(.PHASE(0)) prim_drive (.clk(clk), .reset(reset), .step_n(step_n),
    .dir(dir_pin), .protect(1'b0), .eject(1'b0), .pins(drive_in));
  floppy_drive_model #(.PHASE(60)) ext_drive (.clk(clk), .reset(reset), .step_n(step_n),
    .dir(dir_pin), .protect(ext_protect), .eject(ext_eject), .pins(ext_pins));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_sim;
    if (miscompares == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Four edges cover the config edge plus the registered pin and status paths.
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Open-drain enable high means pin low, so each field follows its request, except density_sel_0, which is inverted.
  function automatic floppy_pin_pkg::drive_od_t exp_od(floppy_pin_pkg::ctl_drive_t c);
    floppy_pin_pkg::drive_od_t e;
    e = {!c.den0, c.side1, c.write_en, c.write_data, c.step, c.inward, c.motor_b,
      c.motor_a, c.sel_a, c.sel_b};
    return e;
  endfunction

  task automatic step_pulse(input logic in_dir);
    @(posedge clk);
    ctl.inward <= in_dir;
    ctl.step <= 1'b1;
    @(posedge clk);
    ctl.step <= 1'b0;
    settle;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_regs;
    logic [7:0] d;
    rd(floppy_pin_pkg::PORT_MODE_ADDR, d);
    chk(d, 8'h00);
    rd(floppy_pin_pkg::PIN_STATUS_ADDR, d);
    chk(d & 8'hF6, 8'h04);
    wr(floppy_pin_pkg::PIN_STATUS_ADDR, 8'hFF);
    wr(4'h9, 8'hFF);
    rd(4'h9, d);
    chk(d, 8'h00);
    rd(floppy_pin_pkg::FLOPPY_CFG_ADDR, d);
    chk(d, 8'h00);
    rd(floppy_pin_pkg::PIN_STATUS_ADDR, d);
    chk(d & 8'hF6, 8'h04);
    wr(floppy_pin_pkg::PIN_SELECT_ADDR, 8'hFE);
    rd(floppy_pin_pkg::PIN_SELECT_ADDR, d);
    chk(d, 8'h02);
    wr(floppy_pin_pkg::FLOPPY_CFG_ADDR, 8'h80);
    settle;
    chk(input_pullup_en, 5'h00);
    wr(floppy_pin_pkg::FLOPPY_CFG_ADDR, 8'h7F);
    settle;
    chk(input_pullup_en, 5'h1F);
  endtask

  task automatic test_printer;
    @(posedge clk);
    pp_data_o <= 8'hA5;
    pp_data_oe <= 8'h0F;
    pp_far <= 8'h3C;
    settle;
    chk(par_data_o, 8'hA5);
    chk(par_data_oe, 8'h0F);
    chk(pp_data_i, 8'h35);
    wr(floppy_pin_pkg::PORT_MODE_ADDR, 8'h03);
    settle;
    chk(par_data_oe, 8'h0F);
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clk);
      ctl <= floppy_pin_pkg::ctl_drive_t'(11'h001 << i);
      settle;
      chk(drive_od_oe, exp_od(ctl));
      chk(drive_od_o, 10'h000);
    end
  endtask

  task automatic test_step;
    @(posedge clk);
    ctl <= '0;
    repeat (3) step_pulse(1'b1);
    chk(ctl_drive_in.track_zero_n, 1'b1);
    chk(ctl_drive_in.media_change_n, 1'b1);
    repeat (2) step_pulse(1'b0);
    chk(ctl_drive_in.track_zero_n, 1'b1);
    step_pulse(1'b0);
    chk(ctl_drive_in.track_zero_n, 1'b0);
  endtask

  // Core drive level and enable pairs differ per source, so a wrong route shows.
  task automatic test_density;
    @(posedge clk);
    ctl.den1 <= 1'b1;
    gp_o <= 1'b1;
    gp_oe <= 1'b0;
    kb_o <= 1'b1;
    kb_oe <= 1'b1;
    d1_far <= 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      wr(floppy_pin_pkg::PIN_SELECT_ADDR, 8'(s));
      settle;
      chk(d1_oe, s[1]);
      chk(d1_o, s[0] ^ s[1]);
      chk(gp_i, s == 1);
      chk(irq_in, s == 1);
      chk(kb_i, s == 2);
    end
    @(posedge clk);
    sys_irq <= 1'b1;
    settle;
    chk(d1_o, 1'b1);
    wr(floppy_pin_pkg::PIN_SELECT_ADDR, 8'h00);
    ctl.den1 <= 1'b0;
    settle;
    chk(d1_oe, 1'b1);
  endtask

  task automatic test_ext;
    floppy_pin_pkg::drive_in_t snap;
    @(posedge clk);
    ext_mode <= 1'b1;
    ext_protect <= 1'b1;
    ext_eject <= 1'b1;
    pp_data_oe <= 8'hFF;
    ctl.motor_a <= 1'b1;
    ctl.sel_a <= 1'b1;
    @(posedge clk);
    ext_eject <= 1'b0;
    wr(floppy_pin_pkg::PORT_MODE_ADDR, 8'h01);
    settle;
    chk(par_data_oe, 8'h00);
    chk(pp_data_i, 8'h00);
    chk(ctl_drive_in.write_protect_n, 1'b1);
    @(posedge clk);
    ctl.sel_b <= 1'b1;
    settle;
    chk(ctl_drive_in.write_protect_n, 1'b0);
    chk(ctl_drive_in.media_change_n, 1'b0);
    wr(floppy_pin_pkg::PORT_MODE_ADDR, 8'h02);
    ctl.sel_b <= 1'b0;
    settle;
    chk(par_data_oe, 8'hC0);
    chk(par_data_o & 8'hC0, 8'h00);
    ctl.sel_a <= 1'b0;
    settle;
    chk(par_data_oe, 8'h40);
    for (int k = 0; k < 8; k++)
    begin
      @(negedge clk);
      snap = ext_pins;
      @(posedge clk);
      #1;
      chk(ctl_drive_in, snap);
    end
  endtask

  // Main sequence; reset drops by the edge that ends the eighth cycle.
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk(par_data_oe, 8'h00);
    chk(input_pullup_en, 5'h1F);
    test_regs();
    test_printer();
    test_step();
    test_density();
    test_ext();
    end_sim();
  end

  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end
endmodule

`default_nettype wire
